// >>> core/pmaa_core.sv
// Monitor back end: sequencer, averaging, result registers and alert
`default_nettype none
module pmaa_core
	import pmaa_pkg::*;
#(
	parameter int CYCLES_PER_US = 25
) (
	input wire logic I_CLK,
	input wire logic I_RESET_N,
	input wire logic I_REG_WR,
	input wire logic I_REG_RD,
	input wire logic [7:0] I_REG_ADDR,
	input wire logic [15:0] I_REG_WDATA,
	output logic [15:0] O_REG_RDATA,
	input wire logic [15:0] I_SHUNT_CODE,
	input wire logic [15:0] I_BUS_CODE,
	output logic O_CONV_SHUNT,
	output logic O_CONV_BUS,
	output logic O_ALERT_OUT,
	output logic O_ALERT_OE
);

	// Elaboration check on the clock scale
	if (CYCLES_PER_US < 1 || CYCLES_PER_US > 80) begin : g_bad_scale
		$error("CYCLES_PER_US out of range");
	end

	// Picks the most significant enabled comparison, one-hot
	function automatic logic [4:0] pick_func(input logic [4:0] en);
		logic [4:0] r;
		r = 5'h0_0;
		if (en[4])
			r = 5'h1_0;
		else if (en[3])
			r = 5'h0_8;
		else if (en[2])
			r = 5'h0_4;
		else if (en[1])
			r = 5'h0_2;
		else if (en[0])
			r = 5'h0_1;
		return r;
	endfunction

	// Conversion period in clock cycles for a time code
	function automatic logic [23:0] conv_cycles(input logic [2:0] code);
		return 24'(CONV_TIME_US[code] * CYCLES_PER_US);
	endfunction

	pmaa_state_type state_q, state_d;
	logic [15:0] cfg_q, limit_q, cal_q;
	logic cal_wr_q;
	logic [4:0] en_q;
	logic conv_done_alert_en_q, pol_q, len_q, aff_q, conv_done_flag_q;
	logic [15:0] shunt_res_q, bus_res_q, cur_res_q, pow_res_q;
	logic [15:0] shunt_smp_q, bus_smp_q, cur_smp_q, pow_smp_q;
	logic [25:0] acc_shunt_q, acc_bus_q, acc_cur_q, acc_pow_q;
	logic [10:0] seq_cnt_q;
	logic [23:0] timer_q, timer_d;
	logic [15:0] shunt_m_q, shunt_s_q, bus_m_q, bus_s_q;
	logic [15:0] rdata_q;
	logic conv_shunt_q, conv_bus_q, alert_oe_q;

	// Register access decode
	wire wr_cfg = I_REG_WR && (I_REG_ADDR == ADDR_CFG);
	wire wr_cal = I_REG_WR && (I_REG_ADDR == ADDR_CAL);
	wire wr_mask = I_REG_WR && (I_REG_ADDR == ADDR_MASK);
	wire wr_limit = I_REG_WR && (I_REG_ADDR == ADDR_LIMIT);
	wire rd_mask = I_REG_RD && (I_REG_ADDR == ADDR_MASK);
	wire [2:0] new_mode = I_REG_WDATA[CFG_MODE_LSB+:3];
	wire new_active = (new_mode[1:0] != 2'b00);

	// Mode fields of the stored configuration
	wire [2:0] mode = cfg_q[CFG_MODE_LSB+:3];
	wire do_shunt = mode[0];
	wire do_bus = mode[1];
	wire continuous = mode[2];
	wire [3:0] avg_shift = 4'(AVG_SHIFT[cfg_q[CFG_AVG_LSB+:3]]);
	wire [10:0] avg_n = 11'(11'h0_01 << avg_shift);

	// Timer reload values, one per conversion kind
	// separate conversion times
	wire [23:0] shunt_len = conv_cycles(cfg_q[CFG_SCT_LSB+:3]) - 24'h00_0001;
	wire [23:0] bus_len = conv_cycles(cfg_q[CFG_BCT_LSB+:3]) - 24'h00_0001;
	wire [23:0] new_shunt_len =
		conv_cycles(I_REG_WDATA[CFG_SCT_LSB+:3]) - 24'h00_0001;
	wire [23:0] new_bus_len =
		conv_cycles(I_REG_WDATA[CFG_BCT_LSB+:3]) - 24'h00_0001;

	// End-of-conversion strobes
	wire shunt_end = (state_q == ST_SHUNT) && (timer_q == 24'h00_0000);
	wire bus_end = (state_q == ST_BUS) && (timer_q == 24'h00_0000);
	wire last_seq = ((seq_cnt_q + 11'h0_01) == avg_n);
	wire seq_done = (state_q == ST_ACC) && last_seq;

	// current from shunt and calibration, zero until calibrated
	wire signed [32:0] cur_prod = $signed(shunt_s_q) * $signed({1'b0, cal_q});
	wire [15:0] cur_val = cal_wr_q ? cur_prod[CUR_SHIFT+:16] : WORD_RESET;

	// power from bus and current, zero until calibrated
	wire [15:0] cur_abs = cur_smp_q[15] ? 16'(-cur_smp_q) : cur_smp_q;
	wire [31:0] pow_prod = cur_abs * bus_s_q;
	wire [31:0] pow_quot = pow_prod / {16'h0000, POWER_DIV};
	wire [15:0] pow_val = cal_wr_q ? pow_quot[15:0] : WORD_RESET;

	// only the highest enabled comparison is served
	wire [4:0] sel = pick_func(en_q);
	wire viol_shunt = (sel[4] && $signed(shunt_s_q) > $signed(limit_q))
		|| (sel[3] && $signed(shunt_s_q) < $signed(limit_q));
	wire viol_bus = (sel[2] && bus_s_q > limit_q)
		|| (sel[1] && bus_s_q < limit_q) || (sel[0] && pow_val > limit_q);
	wire cmp_shunt = shunt_end && (sel[4] || sel[3]);
	wire cmp_bus = bus_end && (sel[2] || sel[1] || sel[0]);
	wire cmp_evt = cmp_shunt || cmp_bus;
	wire viol = (cmp_shunt && viol_shunt) || (cmp_bus && viol_bus);

	// config write and mask read release the alert flag
	wire clr_aff = wr_cfg || rd_mask;
	// ready flag clears on active config write or mask read
	wire clr_conv_done_flag = (wr_cfg && new_active) || rd_mask;

	// flag drives the pin; ready may also drive it
	// ready joins only while its enable is set
	wire alert_on = aff_q || (conv_done_alert_en_q && conv_done_flag_q);
	// open drain, pull down while active-low alert or idle active-high
	wire alert_oe_d = alert_on ^ pol_q;

	// Sequencer next state and timer
	always_comb begin
		state_d = state_q;
		timer_d = (timer_q == 24'h00_0000) ? timer_q : timer_q - 24'h00_0001;
		case (state_q)
			ST_IDLE: begin
				state_d = ST_IDLE;
			end
			ST_SHUNT: begin
				if (shunt_end) begin
					state_d = do_bus ? ST_BUS : ST_ACC;
					timer_d = bus_len;
				end
			end
			ST_BUS: begin
				if (bus_end)
					state_d = ST_ACC;
			end
			ST_ACC: begin
				if (last_seq && !continuous)
					state_d = ST_IDLE;
				else begin
					state_d = do_shunt ? ST_SHUNT : ST_BUS;
					timer_d = do_shunt ? shunt_len : bus_len;
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
		// each active config write starts a fresh cycle; a power-down write goes to idle
		if (wr_cfg) begin
			if (!new_active)
				state_d = ST_IDLE;
			else if (new_mode[0]) begin
				state_d = ST_SHUNT;
				timer_d = new_shunt_len;
			end else begin
				state_d = ST_BUS;
				timer_d = new_bus_len;
			end
		end
	end

	// Accumulated sums including the current sequence
	wire [25:0] sum_shunt = acc_shunt_q + {{10{shunt_smp_q[15]}}, shunt_smp_q};
	wire [25:0] sum_cur = acc_cur_q + {{10{cur_smp_q[15]}}, cur_smp_q};
	wire [25:0] sum_bus = acc_bus_q + {10'h000, bus_smp_q};
	wire [25:0] sum_pow = acc_pow_q + {10'h000, pow_smp_q};
	wire [25:0] avg_shunt = 26'($signed(sum_shunt) >>> avg_shift);
	wire [25:0] avg_cur = 26'($signed(sum_cur) >>> avg_shift);
	wire [25:0] avg_bus = sum_bus >> avg_shift;
	wire [25:0] avg_pow = sum_pow >> avg_shift;

	// Read data selection
	wire [15:0] mask_view = {en_q, conv_done_alert_en_q, 5'h00, aff_q, conv_done_flag_q, 1'b0,
		pol_q, len_q};
	wire [15:0] rd_mux =
		(I_REG_ADDR == ADDR_CFG) ? cfg_q :
		(I_REG_ADDR == ADDR_SHUNT) ? shunt_res_q :
		(I_REG_ADDR == ADDR_BUS) ? bus_res_q :
		(I_REG_ADDR == ADDR_POWER) ? pow_res_q :
		(I_REG_ADDR == ADDR_CURRENT) ? cur_res_q :
		(I_REG_ADDR == ADDR_CAL) ? cal_q :
		(I_REG_ADDR == ADDR_MASK) ? mask_view :
		(I_REG_ADDR == ADDR_LIMIT) ? limit_q : WORD_RESET;

	// Two-flop capture of the converter words
	always_ff @(posedge I_CLK) begin
		shunt_m_q <= I_SHUNT_CODE;
		shunt_s_q <= shunt_m_q;
		bus_m_q <= I_BUS_CODE;
		bus_s_q <= bus_m_q;
	end

	// Host-written registers
	always_ff @(posedge I_CLK) begin
		if (!I_RESET_N) begin
			cfg_q <= CFG_RESET;
			cal_q <= WORD_RESET;
			cal_wr_q <= 1'b0;
			limit_q <= WORD_RESET;
			{en_q, conv_done_alert_en_q, pol_q, len_q} <= 8'h00;
		end else begin
			if (wr_cfg)
				cfg_q <= I_REG_WDATA;
			if (wr_cal) begin
				cal_q <= I_REG_WDATA;
				cal_wr_q <= 1'b1;
			end
			if (wr_limit)
				limit_q <= I_REG_WDATA;
			if (wr_mask)
				{en_q, conv_done_alert_en_q, pol_q, len_q} <= {I_REG_WDATA[15:10],
					I_REG_WDATA[MSK_ALERT_POLARITY_SEL], I_REG_WDATA[MSK_LEN]};
		end
	end

	// Sequencer state and per-conversion samples
	always_ff @(posedge I_CLK) begin
		if (!I_RESET_N) begin
			state_q <= ST_IDLE;
			timer_q <= 24'h00_0000;
			{shunt_smp_q, cur_smp_q, bus_smp_q} <= 48'h0000_0000_0000;
			pow_smp_q <= WORD_RESET;
		end else begin
			// interval is the enabled conversion times plus one accumulate cycle per sequence
			state_q <= state_d;
			timer_q <= timer_d;
			if (shunt_end) begin
				shunt_smp_q <= shunt_s_q;
				cur_smp_q <= cur_val;
			end
			if (bus_end) begin
				bus_smp_q <= bus_s_q;
				pow_smp_q <= pow_val;
			end
		end
	end

	// Accumulators and sequence count
	always_ff @(posedge I_CLK) begin
		if (!I_RESET_N || wr_cfg || seq_done) begin
			{acc_shunt_q, acc_cur_q} <= 52'h0_0000_0000_0000;
			{acc_bus_q, acc_pow_q} <= 52'h0_0000_0000_0000;
			seq_cnt_q <= 11'h0_00;
		end else if (state_q == ST_ACC) begin
			// current and power; shunt and bus
			acc_shunt_q <= sum_shunt;
			acc_cur_q <= sum_cur;
			acc_bus_q <= sum_bus;
			acc_pow_q <= sum_pow;
			seq_cnt_q <= seq_cnt_q + 11'h0_01;
		end
	end

	// Result registers update only when the average count completes
	always_ff @(posedge I_CLK) begin
		if (!I_RESET_N) begin
			{shunt_res_q, bus_res_q} <= 32'h0000_0000;
			{cur_res_q, pow_res_q} <= 32'h0000_0000;
		end else if (seq_done) begin
			shunt_res_q <= avg_shunt[15:0];
			bus_res_q <= avg_bus[15:0];
			cur_res_q <= avg_cur[15:0];
			pow_res_q <= avg_pow[15:0];
		end
	end

	// Status flags: a set in the same cycle as a clear wins
	always_ff @(posedge I_CLK) begin
		if (!I_RESET_N) begin
			conv_done_flag_q <= 1'b0;
			aff_q <= 1'b0;
		end else begin
			conv_done_flag_q <= seq_done || (conv_done_flag_q && !clr_conv_done_flag);
			// latched hold; unlatched follows each check
			if (viol)
				aff_q <= 1'b1;
			else if (clr_aff || (cmp_evt && !len_q))
				aff_q <= 1'b0;
		end
	end

	// Registered outputs
	always_ff @(posedge I_CLK) begin
		if (!I_RESET_N) begin
			rdata_q <= WORD_RESET;
			conv_shunt_q <= 1'b0;
			conv_bus_q <= 1'b0;
			alert_oe_q <= 1'b0;
		end else begin
			if (I_REG_RD)
				rdata_q <= rd_mux;
			conv_shunt_q <= (state_d == ST_SHUNT);
			conv_bus_q <= (state_d == ST_BUS);
			alert_oe_q <= alert_oe_d;
		end
	end

	assign O_REG_RDATA = rdata_q;
	assign O_CONV_SHUNT = conv_shunt_q;
	assign O_CONV_BUS = conv_bus_q;
	assign O_ALERT_OE = alert_oe_q;
	assign O_ALERT_OUT = 1'b0;

	// Checks on the sequencer, flags and alert pin
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (!I_RESET_N);

	a_conv_done_flag_after_avg: assert property (
		$rose(conv_done_flag_q) |-> $past(state_q) == ST_ACC && $past(last_seq))
		else $error("ready flag rose outside sequence end");
	a_conv_done_flag_read_clear: assert property (
		rd_mask && !seq_done |=> !conv_done_flag_q)
		else $error("ready flag survived a mask read");
	a_current_uncal: assert property (
		!cal_wr_q |-> cur_res_q == 16'h0000)
		else $error("current nonzero before calibration");
	a_power_uncal: assert property (
		!cal_wr_q |-> pow_res_q == 16'h0000)
		else $error("power nonzero before calibration");
	a_result_hold: assert property (
		state_q == ST_ACC && !last_seq |=> $stable(cur_res_q)
			&& $stable(shunt_res_q))
		else $error("results changed before average count");
	a_one_function: assert property (
		$onehot0(sel) && (!en_q[4] || sel[4]))
		else $error("priority select not one-hot");
	a_shunt_over: assert property (
		shunt_end && sel[4] && $signed(shunt_s_q) > $signed(limit_q)
			|=> aff_q ##1 O_ALERT_OE == !pol_q)
		else $error("shunt over-limit missed");
	a_latch_hold: assert property (
		aff_q && len_q && !clr_aff |=> aff_q)
		else $error("latched alert flag dropped");
	a_unlatch_drop: assert property (
		cmp_evt && !viol && !len_q |=> !aff_q)
		else $error("unlatched flag not cleared");
	a_ready_alert: assert property (
		$rose(conv_done_flag_q) && conv_done_alert_en_q && !pol_q && !$rose(conv_done_alert_en_q) |=> O_ALERT_OE)
		else $error("ready did not assert alert");
	a_powerdown_idle: assert property (
		state_q == ST_IDLE && !wr_cfg |=> state_q == ST_IDLE)
		else $error("conversion started without config write");

endmodule : pmaa_core
`default_nettype wire

// >>> include/pmaa_pkg.sv
// Package: register map, field layout, reset values and timing tables
`default_nettype none
package pmaa_pkg;
	// Register offsets
	localparam logic [7:0] ADDR_CFG = 8'h00;
	localparam logic [7:0] ADDR_SHUNT = 8'h01;
	localparam logic [7:0] ADDR_BUS = 8'h02;
	localparam logic [7:0] ADDR_POWER = 8'h03;
	localparam logic [7:0] ADDR_CURRENT = 8'h04;
	localparam logic [7:0] ADDR_CAL = 8'h05;
	localparam logic [7:0] ADDR_MASK = 8'h06;
	localparam logic [7:0] ADDR_LIMIT = 8'h07;
	// Configuration field positions
	localparam int CFG_MODE_LSB = 0;
	localparam int CFG_SCT_LSB = 3;
	localparam int CFG_BCT_LSB = 6;
	localparam int CFG_AVG_LSB = 9;
	// Mask/enable field positions
	localparam int MSK_SOL = 15;
	localparam int MSK_SUL = 14;
	localparam int MSK_BOL = 13;
	localparam int MSK_BUL = 12;
	localparam int MSK_POL = 11;
	localparam int MSK_CONV_DONE_ALERT_EN = 10;
	localparam int MSK_AFF = 4;
	localparam int MSK_CONV_DONE_FLAG = 3;
	localparam int MSK_ALERT_POLARITY_SEL = 1;
	localparam int MSK_LEN = 0;
	// Reset values
	localparam logic [15:0] CFG_RESET = 16'h0127;
	localparam logic [15:0] WORD_RESET = 16'h0000;
	// Conversion times in microseconds, selected by a 3-bit code
	localparam int CONV_TIME_US [8] = '{150, 204, 332, 588, 1036, 2116,
		4156, 7736};
	// Average count as a power of two, selected by a 3-bit code
	localparam int AVG_SHIFT [8] = '{0, 2, 4, 6, 7, 8, 9, 10};
	// Current and power scaling
	localparam int CUR_SHIFT = 11;
	localparam logic [15:0] POWER_DIV = 16'h4E20;
	// Sequencer states
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SHUNT = 2'b01,
		ST_BUS = 2'b10,
		ST_ACC = 2'b11
	} pmaa_state_type;
endpackage : pmaa_pkg
`default_nettype wire

// >>> sim/pmaa_conv_model.sv
// Converter front end model stepping its words once per sequence
`default_nettype none
module pmaa_conv_model (
	input wire logic i_clk,
	input wire logic i_conv_bus,
	input wire logic i_restart,
	input wire logic [15:0] i_shunt_base,
	input wire logic [15:0] i_bus_base,
	input wire logic [15:0] i_step,
	output logic [15:0] o_shunt_code,
	output logic [15:0] o_bus_code
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] k_q;
	logic bus_q;
	// Step after a bus conversion ends, far from the next sample point
	always @(posedge i_clk) begin
		bus_q <= i_conv_bus;
		if (i_restart)
			k_q <= 16'h0000;
		else if (bus_q && !i_conv_bus)
			k_q <= k_q + 16'h0001;
	end
	// Words seen by the sampling flops
	assign o_shunt_code = i_shunt_base + i_step * k_q;
	assign o_bus_code = i_bus_base + i_step * k_q;
endmodule // pmaa_conv_model
`default_nettype wire

// >>> sim/power_monitor_average_alert_bench.sv
// Testbench for the monitor back end
`default_nettype none
module power_monitor_average_alert_bench import pmaa_pkg::*; ();
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, rst_n, wr, rd, restart, conv_s, conv_b, a_out, a_oe;
	logic [7:0] addr;
	logic [15:0] wdata, rdata, shunt, bus, sb, bb, step;
	int err_count, total_checks;
	// Clock at 40 ns
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	pmaa_core #(.CYCLES_PER_US(1)) u_pmaa_core (.I_CLK(clk),
		.I_RESET_N(rst_n), .I_REG_WR(wr), .I_REG_RD(rd),
		.I_REG_ADDR(addr), .I_REG_WDATA(wdata), .O_REG_RDATA(rdata),
		.I_SHUNT_CODE(shunt), .I_BUS_CODE(bus), .O_CONV_SHUNT(conv_s),
		.O_CONV_BUS(conv_b), .O_ALERT_OUT(a_out), .O_ALERT_OE(a_oe));
	pmaa_conv_model u_pmaa_conv_model (.i_clk(clk), .i_conv_bus(conv_b),
		.i_restart(restart), .i_shunt_base(sb), .i_bus_base(bb),
		.i_step(step), .o_shunt_code(shunt), .o_bus_code(bus));
	// Compare and count
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
		@(negedge clk);
		wr = 1'b1;
		addr = a;
		wdata = d;
		@(negedge clk);
		wr = 1'b0;
	endtask
	task automatic reg_rd(input logic [7:0] a, output logic [15:0] d);
		@(negedge clk);
		rd = 1'b1;
		addr = a;
		@(negedge clk);
		rd = 1'b0;
		d = rdata;
	endtask
	// Wait for n bus conversions to end, bounded
	task automatic wait_seq(input int n);
		int t;
		for (int i = 0; i < n; i++) begin
			t = 0;
			while (!conv_b && t < 2000) begin
				@(negedge clk);
				t++;
			end
			// A conversion that never starts counts as a mismatch
			if (!conv_b)
				err_count++;
			while (conv_b && t < 4000) begin
				@(negedge clk);
				t++;
			end
			// A conversion that never ends counts as a mismatch
			if (conv_b)
				err_count++;
		end
		repeat (4) @(negedge clk);
	endtask
	// Count busy cycles of both conversions over a span
	task automatic busy(input int span, output int ns, output int nb);
		ns = 0;
		nb = 0;
		// Sample first: the write edge has already raised the busy level
		repeat (span) begin
			ns += int'(conv_s);
			nb += int'(conv_b);
			@(negedge clk);
		end
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// Reset view, power and current results, mask and limit empty and pin idle
	task automatic t_reset;
		logic [15:0] d;
		check(16'(a_oe), 16'h0000);
		for (int i = 3; i < 9; i++) begin
			if (i != 5) begin
				reg_rd(8'(i), d);
				check(d, 16'h0000);
			end
		end
	endtask
	// Single shot before calibration
	task automatic t_uncal;
		logic [15:0] d;
		reg_wr(ADDR_CFG, 16'h0003);
		reg_rd(ADDR_MASK, d);
		check(16'(d[MSK_CONV_DONE_FLAG]), 16'h0000);
		wait_seq(1);
		reg_rd(ADDR_SHUNT, d);
		check(d, 16'h1F40);
		reg_rd(ADDR_CURRENT, d);
		check(d, 16'h0000);
		reg_rd(ADDR_POWER, d);
		check(d, 16'h0000);
		reg_rd(ADDR_MASK, d);
		check(16'(d[MSK_CONV_DONE_FLAG]), 16'h0001);
		reg_rd(ADDR_MASK, d);
		check(16'(d[MSK_CONV_DONE_FLAG]), 16'h0000);
	endtask
	// Calibrated shot with unequal conversion times
	task automatic t_cal;
		logic [15:0] d;
		int ns, nb;
		reg_wr(ADDR_CAL, 16'h0A00);
		reg_wr(ADDR_CFG, 16'h000B);
		busy(1000, ns, nb);
		check(16'(ns), 16'h00CC);
		check(16'(nb), 16'h0096);
		reg_rd(ADDR_CURRENT, d);
		check(d, 16'h2710);
		reg_rd(ADDR_POWER, d);
		check(d, 16'h12B8);
		reg_wr(ADDR_CFG, 16'h0003);
		reg_rd(ADDR_MASK, d);
		check(16'(d[MSK_CONV_DONE_FLAG]), 16'h0000);
		wait_seq(1);
	endtask
	// Four averages of stepping words
	task automatic t_avg;
		logic [15:0] d;
		int ns, nb;
		sb = 16'h03E8;
		bb = 16'h07D0;
		step = 16'h0004;
		@(negedge clk);
		restart = 1'b1;
		@(negedge clk);
		restart = 1'b0;
		reg_wr(ADDR_CFG, 16'h0203);
		wait_seq(1);
		reg_rd(ADDR_SHUNT, d);
		check(d, 16'h1F40);
		reg_rd(ADDR_MASK, d);
		check(16'(d[MSK_CONV_DONE_FLAG]), 16'h0000);
		wait_seq(3);
		reg_rd(ADDR_SHUNT, d);
		check(d, 16'h03EE);
		reg_rd(ADDR_BUS, d);
		check(d, 16'h07D6);
		reg_rd(ADDR_MASK, d);
		check(16'(d[MSK_CONV_DONE_FLAG]), 16'h0001);
		busy(400, ns, nb);
		check(16'(ns + nb), 16'h0000);
		sb = 16'h1F40;
		bb = 16'h2570;
		step = 16'h0000;
	endtask
	// Continuous run, latched then transparent alert, then power-down
	task automatic t_cont;
		logic [15:0] d;
		int ns, nb;
		reg_wr(ADDR_LIMIT, 16'h1F3F);
		reg_wr(ADDR_MASK, 16'h8001);
		reg_wr(ADDR_CFG, 16'h0007);
		wait_seq(1);
		check(16'(a_oe), 16'h0001);
		reg_wr(ADDR_LIMIT, 16'h1F41);
		wait_seq(2);
		check(16'(a_oe), 16'h0001);
		reg_rd(ADDR_MASK, d);
		check(16'(d[MSK_AFF]), 16'h0001);
		repeat (2) @(negedge clk);
		check(16'(a_oe), 16'h0000);
		reg_wr(ADDR_MASK, 16'h8000);
		reg_wr(ADDR_LIMIT, 16'h1F3F);
		wait_seq(1);
		check(16'(a_oe), 16'h0001);
		reg_wr(ADDR_LIMIT, 16'h1F41);
		wait_seq(1);
		check(16'(a_oe), 16'h0000);
		reg_wr(ADDR_CFG, 16'h0000);
		busy(400, ns, nb);
		check(16'(ns + nb), 16'h0000);
		reg_rd(ADDR_LIMIT, d);
		check(d, 16'h1F41);
	endtask
	// Every comparison, priority and polarity, one shot per row
	task automatic t_alerts;
		localparam logic [15:0] MSK [13] = '{16'h8000, 16'h8000,
			16'h4000, 16'h4000, 16'h2000, 16'h2000, 16'h1000, 16'h1000,
			16'h0800, 16'h0800, 16'hC000, 16'h8002, 16'h8002};
		localparam logic [15:0] LIM [13] = '{16'h1F3F, 16'h1F41,
			16'h1F41, 16'h1F3F, 16'h256F, 16'h2571, 16'h2571, 16'h256F,
			16'h12B7, 16'h12B9, 16'h1F41, 16'h1F3F, 16'h1F41};
		localparam logic [15:0] EXP [13] = '{16'h0001, 16'h0000,
			16'h0001, 16'h0000, 16'h0001, 16'h0000, 16'h0001, 16'h0000,
			16'h0001, 16'h0000, 16'h0000, 16'h0000, 16'h0001};
		for (int i = 0; i < 13; i++) begin
			reg_wr(ADDR_MASK, MSK[i]);
			reg_wr(ADDR_LIMIT, LIM[i]);
			reg_wr(ADDR_CFG, 16'h0003);
			wait_seq(1);
			check(16'(a_oe), EXP[i]);
			check(16'(a_out), 16'h0000);
		end
	endtask
	// Conversion-ready on the pin, found and cleared by a mask read
	task automatic t_conv_done_alert_en;
		logic [15:0] d;
		reg_wr(ADDR_MASK, 16'h0400);
		reg_wr(ADDR_CFG, 16'h0003);
		wait_seq(1);
		check(16'(a_oe), 16'h0001);
		reg_rd(ADDR_MASK, d);
		check(16'(d[MSK_CONV_DONE_FLAG]), 16'h0001);
		repeat (2) @(negedge clk);
		check(16'(a_oe), 16'h0000);
	endtask
	// Main sequence
	initial begin
		rst_n = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		addr = 8'h00;
		wdata = 16'h0000;
		restart = 1'b1;
		sb = 16'h1F40;
		bb = 16'h2570;
		step = 16'h0000;
		err_count = 0;
		total_checks = 0;
		repeat (4) @(negedge clk);
		rst_n = 1'b1;
		restart = 1'b0;
		t_reset;
		t_uncal;
		t_cal;
		t_avg;
		t_cont;
		t_alerts;
		t_conv_done_alert_en;
		tally_and_finish;
	end
	// Watchdog well beyond the expected run length
	initial begin
		repeat (40000) @(posedge clk);
		err_count++;
		tally_and_finish;
	end
endmodule // power_monitor_average_alert_bench
`default_nettype wire
